// ==== spd_regs.vh ====
// Register offsets, field positions and reset values of the serial DMA block.
`ifndef SPD_REGS_VH
`define SPD_REGS_VH

// Register address layout: one bit picks the serial port, six bits the byte.
`define SPD_ADDR_W      7
`define SPD_PORT_BIT    6

// Byte offsets inside one serial port's register space.
`define SPD_OFS_IEN     6'h08
`define SPD_OFS_IDIS    6'h0C
`define SPD_OFS_IMSK    6'h10
`define SPD_OFS_STAT    6'h14
`define SPD_OFS_RPTR    6'h30
`define SPD_OFS_RCNT    6'h34
`define SPD_OFS_TPTR    6'h38
`define SPD_OFS_TCNT    6'h3C

// Positions in the one-hot register select vector.
`define SPD_SEL_IEN     0
`define SPD_SEL_IDIS    1
`define SPD_SEL_IMSK    2
`define SPD_SEL_STAT    3
`define SPD_SEL_RPTR    4
`define SPD_SEL_RCNT    5
`define SPD_SEL_TPTR    6
`define SPD_SEL_TCNT    7

// Status and mask bit positions.
`define SPD_BIT_RXDONE  0
`define SPD_BIT_TXDONE  1

// Reset values.
`define SPD_PTR_RST     32'h00000000
`define SPD_CNT_RST     16'h0000
`define SPD_FLG_RST     4'h0

`endif

// ==== spd_pair_buf.v ====
// Two-entry elastic buffer with valid and ready on both sides.
`timescale 1ns/1ps
module spd_pair_buf #(
  parameter WIDTH = 8
) (
  input  wire             mclk,
  input  wire             reset,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);

  reg  [WIDTH-1:0] head_ff;   // Oldest word, drives the output directly.
  reg  [WIDTH-1:0] tail_ff;   // Second word, only valid when two are held.
  reg  [1:0]       fill_ff;   // Number of words held, zero to two.
  wire             push;      // A word enters this cycle.
  wire             pop;       // A word leaves this cycle.

  assign inReady  = (fill_ff != 2'h2);
  assign outValid = (fill_ff != 2'h0);
  assign outData  = head_ff;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Shift-style storage keeps the head in a register, so the output never
  // passes through a multiplexer after the flop.
  always @(posedge mclk) begin
    if (reset) begin
      head_ff <= {WIDTH{1'b0}};
      tail_ff <= {WIDTH{1'b0}};
      fill_ff <= 2'h0;
    end else if (push && !pop) begin
      if (fill_ff == 2'h0) begin
        head_ff <= inData;
      end else begin
        tail_ff <= inData;
      end
      fill_ff <= fill_ff + 2'h1;
    end else if (pop && !push) begin
      head_ff <= tail_ff;
      fill_ff <= fill_ff - 2'h1;
    end else if (pop && push) begin
      // One in and one out: the count stays, the words move up.
      if (fill_ff == 2'h1) begin
        head_ff <= inData;
      end else begin
        head_ff <= tail_ff;
        tail_ff <= inData;
      end
    end
  end

endmodule

// ==== spd_rr_arb.v ====
// Round-robin arbiter that picks one of four channel requests.
`timescale 1ns/1ps
module spd_rr_arb (
  input  wire       mclk,
  input  wire       reset,
  input  wire [3:0] reqVec,
  input  wire       advance,
  output reg  [1:0] grantIdx,
  output wire       anyReq
);

  reg  [1:0] lastGrant_ff;    // Channel served most recently.
  reg  [1:0] probe;           // Candidate channel inside the search.
  reg        found;           // A candidate has been picked.
  integer    k;

  assign anyReq = |reqVec;

  // Search starts just after the last winner so no channel starves.
  always @* begin
    found    = 1'b0;
    probe    = 2'h0;
    grantIdx = lastGrant_ff;
    for (k = 1; k <= 4; k = k + 1) begin
      probe = lastGrant_ff + k[1:0];
      if (!found && reqVec[probe]) begin
        grantIdx = probe;
        found    = 1'b1;
      end
    end
  end

  // The winner is remembered only when the engine really takes it.
  always @(posedge mclk) begin
    if (reset) begin
      lastGrant_ff <= 2'h3;
    end else if (advance) begin
      lastGrant_ff <= grantIdx;
    end
  end

endmodule

// ==== spd_channels.v ====
// Four-channel character DMA engine serving two serial ports.
//
// Function
// R01: Four channels: receive and transmit per port.
// R02: Channel registers sit in each port's space.
// R03: Each channel holds a 32-bit memory pointer.
// R04: Each channel holds a 16-bit transfer count.
// R05: Count reaching zero sets end-of-transfer status.
// R06: End-of-transfer status raises masked port interrupt.
// R07: Each transfer: pointer plus one, count minus one.
`timescale 1ns/1ps
`include "spd_regs.vh"
module spd_channels (
  input  wire                   mclk,
  input  wire                   reset,
  input  wire [`SPD_ADDR_W-1:0] regAddr,
  input  wire [31:0]            regWrData,
  input  wire                   regWrStb,
  input  wire                   regRdStb,
  output wire [31:0]            regRdData,
  input  wire [1:0]             rxValid,
  input  wire [7:0]             rxData0,
  input  wire [7:0]             rxData1,
  output wire [1:0]             rxReady,
  output wire [1:0]             txValid,
  output wire [7:0]             txData0,
  output wire [7:0]             txData1,
  input  wire [1:0]             txReady,
  output wire                   memReq,
  output wire                   memWrite,
  output wire [31:0]            memAddr,
  output wire [7:0]             memWrData,
  input  wire [7:0]             memRdData,
  input  wire                   memAck,
  output wire [1:0]             usartIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  ////////////////////////////////////////////////////////////////////////////

  // Engine states, one-hot.
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BUSY = 2'b10;

  // Channel index is {port, direction}; direction 0 receives, 1 transmits.
  reg  [31:0] chanPtr_ff [0:3];  // Memory pointer of each channel.
  reg  [15:0] chanCnt_ff [0:3];  // Transfers left on each channel.
  reg  [3:0]  doneFlag_ff;       // Sticky end-of-transfer per channel.
  reg  [3:0]  irqMask_ff;        // Interrupt mask per channel.
  reg  [1:0]  state_ff;          // Engine state.
  reg  [1:0]  nxt_state;         // Engine state for the next cycle.
  reg  [1:0]  curChan_ff;        // Channel owning the memory access.
  reg         memReq_ff;         // Memory request, held until acknowledge.
  reg         memWrite_ff;       // Direction of the memory access.
  reg  [31:0] memAddr_ff;        // Address of the memory access.
  reg  [7:0]  memWrData_ff;      // Received character going to memory.
  reg  [31:0] rdData_ff;         // Read data, valid the cycle after a read.
  wire [3:0]  reqVec;            // Channels that could move a character.
  wire [1:0]  grantIdx;          // Channel chosen by the arbiter.
  wire        anyReq;            // At least one channel is ready.
  wire        take;              // The engine starts an access this cycle.
  wire        ackHit;            // The pending access completes this cycle.
  wire [1:0]  bufInReady;        // Transmit buffers with a free entry.
  wire [1:0]  bufInValid;        // Fetched character enters a buffer.
  wire [15:0] txDataVec;         // Both transmit buffer outputs.
  wire [7:0]  wrSel;             // Register written this cycle.
  wire [7:0]  rdSel;             // Register read this cycle.
  wire        selPort;           // Serial port addressed by software.
  wire [1:0]  rxCh;              // Receive channel of the addressed port.
  wire [1:0]  txCh;              // Transmit channel of the addressed port.
  wire [3:0]  flagSet;           // Channels finishing their last transfer.
  wire [3:0]  flagClr;           // Channels whose count is rewritten.
  wire [1:0]  portMask;          // Mask bits of the addressed port.
  wire [1:0]  portDone;          // Status bits of the addressed port.
  integer     i;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.
  ////////////////////////////////////////////////////////////////////////////

  // Turns a byte offset into a one-hot select; unmapped offsets give zero.
  function [7:0] regSel;
    input [5:0] ofs;
    begin
      regSel = 8'h00;
      case (ofs)
        `SPD_OFS_IEN:  regSel[`SPD_SEL_IEN]  = 1'b1;
        `SPD_OFS_IDIS: regSel[`SPD_SEL_IDIS] = 1'b1;
        `SPD_OFS_IMSK: regSel[`SPD_SEL_IMSK] = 1'b1;
        `SPD_OFS_STAT: regSel[`SPD_SEL_STAT] = 1'b1;
        `SPD_OFS_RPTR: regSel[`SPD_SEL_RPTR] = 1'b1;
        `SPD_OFS_RCNT: regSel[`SPD_SEL_RCNT] = 1'b1;
        `SPD_OFS_TPTR: regSel[`SPD_SEL_TPTR] = 1'b1;
        `SPD_OFS_TCNT: regSel[`SPD_SEL_TCNT] = 1'b1;
        default:       regSel = 8'h00;
      endcase
    end
  endfunction

  // The port bit of the address picks whose register space is used.
  assign selPort = regAddr[`SPD_PORT_BIT];                           // R02
  assign rxCh    = {selPort, 1'b0};
  assign txCh    = {selPort, 1'b1};
  assign wrSel   = regSel(regAddr[5:0]) & {8{regWrStb}};
  assign rdSel   = regSel(regAddr[5:0]);

  // Rewriting a count starts a new block, so its old end flag goes away.
  assign flagClr[0] = wrSel[`SPD_SEL_RCNT] & ~selPort;
  assign flagClr[1] = wrSel[`SPD_SEL_TCNT] & ~selPort;
  assign flagClr[2] = wrSel[`SPD_SEL_RCNT] & selPort;
  assign flagClr[3] = wrSel[`SPD_SEL_TCNT] & selPort;

  ////////////////////////////////////////////////////////////////////////////
  // Channel requests and transmit buffers.
  ////////////////////////////////////////////////////////////////////////////

  // One receive and one transmit channel per port.
  genvar u;
  generate
    for (u = 0; u < 2; u = u + 1) begin : gPort
      // A receive channel asks when a character waits and work is left.
      assign reqVec[2*u]   = rxValid[u] && (chanCnt_ff[2*u] != 16'h0000);
      // A transmit channel asks only when its buffer can take the word.
      assign reqVec[2*u+1] = bufInReady[u] &&
                             (chanCnt_ff[2*u+1] != 16'h0000);      // R07
      // The character is accepted in the cycle the engine takes it.
      assign rxReady[u]    = take && (grantIdx == 2*u);
      // The fetched character enters the buffer on the acknowledge.
      assign bufInValid[u] = ackHit && (curChan_ff == 2*u+1);

      // A stall by the transmitter fills this buffer and then holds off
      // further fetches; one slot is always free when a fetch starts.
      spd_pair_buf #(
        .WIDTH    (8)
      ) uTxBuf (
        .mclk     (mclk),
        .reset    (reset),
        .inValid  (bufInValid[u]),
        .inReady  (bufInReady[u]),
        .inData   (memRdData),
        .outValid (txValid[u]),
        .outReady (txReady[u]),
        .outData  (txDataVec[8*u+7:8*u])
      );
    end
  endgenerate                                                        // R01

  assign txData0 = txDataVec[7:0];
  assign txData1 = txDataVec[15:8];

  // The four channels share the memory port in turn.
  spd_rr_arb uArb (
    .mclk     (mclk),
    .reset    (reset),
    .reqVec   (reqVec),
    .advance  (take),
    .grantIdx (grantIdx),
    .anyReq   (anyReq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine.
  ////////////////////////////////////////////////////////////////////////////

  assign take   = (state_ff == ST_IDLE) && anyReq;
  assign ackHit = (state_ff == ST_BUSY) && memAck;

  // Only one access is in flight, which keeps the buffer slot reserved.
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (anyReq) begin
          nxt_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (memAck) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // The access is launched from flops and held until it is acknowledged.
  always @(posedge mclk) begin
    if (reset) begin
      state_ff     <= ST_IDLE;
      curChan_ff   <= 2'h0;
      memReq_ff    <= 1'b0;
      memWrite_ff  <= 1'b0;
      memAddr_ff   <= `SPD_PTR_RST;
      memWrData_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      if (take) begin
        curChan_ff   <= grantIdx;
        memReq_ff    <= 1'b1;
        // Receive channels write memory, transmit channels read it.
        memWrite_ff  <= ~grantIdx[0];                                // R03
        memAddr_ff   <= chanPtr_ff[grantIdx];                        // R03
        memWrData_ff <= grantIdx[1] ? rxData1 : rxData0;
      end else if (ackHit) begin
        memReq_ff <= 1'b0;
      end
    end
  end

  assign memReq    = memReq_ff;
  assign memWrite  = memWrite_ff;
  assign memAddr   = memAddr_ff;
  assign memWrData = memWrData_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Channel registers and status.
  ////////////////////////////////////////////////////////////////////////////

  // The last transfer of a block is the one that leaves the count at zero.
  generate
    for (u = 0; u < 4; u = u + 1) begin : gFlag
      assign flagSet[u] = ackHit && (curChan_ff == u) &&
                          (chanCnt_ff[u] == 16'h0001);               // R05
    end
  endgenerate

  // A software write wins over the step of the same cycle, because it is
  // the later assignment; a write during an access gets stepped on its ack.
  always @(posedge mclk) begin
    if (reset) begin
      for (i = 0; i < 4; i = i + 1) begin
        chanPtr_ff[i] <= `SPD_PTR_RST;
        chanCnt_ff[i] <= `SPD_CNT_RST;
      end
    end else begin
      if (ackHit) begin
        chanPtr_ff[curChan_ff] <= chanPtr_ff[curChan_ff] + 32'h1;   // R07
        chanCnt_ff[curChan_ff] <= chanCnt_ff[curChan_ff] - 16'h1;   // R07
      end
      if (wrSel[`SPD_SEL_RPTR]) begin
        chanPtr_ff[rxCh] <= regWrData;                               // R03
      end
      if (wrSel[`SPD_SEL_TPTR]) begin
        chanPtr_ff[txCh] <= regWrData;                               // R03
      end
      if (wrSel[`SPD_SEL_RCNT]) begin
        chanCnt_ff[rxCh] <= regWrData[15:0];                         // R04
      end
      if (wrSel[`SPD_SEL_TCNT]) begin
        chanCnt_ff[txCh] <= regWrData[15:0];                         // R04
      end
    end
  end

  // End flags are sticky; a completion in the clearing cycle still sets.
  always @(posedge mclk) begin
    if (reset) begin
      doneFlag_ff <= `SPD_FLG_RST;
    end else begin
      doneFlag_ff <= (doneFlag_ff & ~flagClr) | flagSet;             // R05
    end
  end

  // Mask bits are set by the enable write and cleared by the disable write.
  always @(posedge mclk) begin
    if (reset) begin
      irqMask_ff <= `SPD_FLG_RST;
    end else if (wrSel[`SPD_SEL_IEN]) begin
      if (selPort) begin
        irqMask_ff[3:2] <= irqMask_ff[3:2] | regWrData[1:0];         // R06
      end else begin
        irqMask_ff[1:0] <= irqMask_ff[1:0] | regWrData[1:0];         // R06
      end
    end else if (wrSel[`SPD_SEL_IDIS]) begin
      if (selPort) begin
        irqMask_ff[3:2] <= irqMask_ff[3:2] & ~regWrData[1:0];        // R06
      end else begin
        irqMask_ff[1:0] <= irqMask_ff[1:0] & ~regWrData[1:0];        // R06
      end
    end
  end

  // Each port's interrupt is the OR of its unmasked end flags.
  assign usartIrq[0] = |(doneFlag_ff[1:0] & irqMask_ff[1:0]);        // R06
  assign usartIrq[1] = |(doneFlag_ff[3:2] & irqMask_ff[3:2]);        // R06

  ////////////////////////////////////////////////////////////////////////////
  // Register read port.
  ////////////////////////////////////////////////////////////////////////////

  assign portMask = selPort ? irqMask_ff[3:2] : irqMask_ff[1:0];
  assign portDone = selPort ? doneFlag_ff[3:2] : doneFlag_ff[1:0];

  // Read data stand in the cycle after the strobe only; write-only and
  // unmapped offsets read as zero, as do all unused upper bits.
  always @(posedge mclk) begin
    if (reset) begin
      rdData_ff <= 32'h00000000;
    end else if (regRdStb) begin
      rdData_ff <= 32'h00000000;
      if (rdSel[`SPD_SEL_IMSK]) begin
        rdData_ff <= {30'h00000000, portMask};
      end
      if (rdSel[`SPD_SEL_STAT]) begin
        rdData_ff <= {30'h00000000, portDone};                       // R05
      end
      if (rdSel[`SPD_SEL_RPTR]) begin
        rdData_ff <= chanPtr_ff[rxCh];
      end
      if (rdSel[`SPD_SEL_RCNT]) begin
        rdData_ff <= {16'h0000, chanCnt_ff[rxCh]};
      end
      if (rdSel[`SPD_SEL_TPTR]) begin
        rdData_ff <= chanPtr_ff[txCh];
      end
      if (rdSel[`SPD_SEL_TCNT]) begin
        rdData_ff <= {16'h0000, chanCnt_ff[txCh]};
      end
    end else begin
      rdData_ff <= 32'h00000000;
    end
  end

  assign regRdData = rdData_ff;

endmodule

// ==== spd_mem_model.sv ====
// Byte-wide system memory answering the DMA engine's memory port.
`timescale 1ns/1ps
module spd_mem_model (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [31:0] memAddr,
  input  wire logic [7:0]  memWrData,
  output logic      [7:0]  memRdData,
  output logic             memAck,
  input  wire logic        slow
);
  // Only the low address byte is decoded, so tests keep their data apart.
  logic [7:0] mem [256];
  logic [2:0] waitCnt_ff;
  logic [2:0] nxt_limit;

  // Slow mode stretches each access by one to four cycles by address.
  assign nxt_limit = slow ? {1'b0, memAddr[1:0]} + 3'h1 : 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // One access at a time; read data is inverted every idle cycle so a
  // stale byte can never pass for a fresh one.
  always @(posedge mclk) begin
    if (reset) begin
      memAck     <= 1'b0;
      waitCnt_ff <= 3'h0;
      memRdData  <= 8'h00;
    end else begin
      memAck    <= 1'b0;
      memRdData <= ~memRdData;
      if (memReq && !memAck) begin
        if (waitCnt_ff == nxt_limit) begin
          memAck     <= 1'b1;
          waitCnt_ff <= 3'h0;
          if (memWrite) begin
            mem[memAddr[7:0]] <= memWrData;
          end else begin
            memRdData <= mem[memAddr[7:0]];
          end
        end else begin
          waitCnt_ff <= waitCnt_ff + 3'h1;
        end
      end
    end
  end
endmodule

// ==== spd_channels_assertions.sv ====
// Concurrent checks on the ports of the serial DMA engine.
`timescale 1ns/1ps
module spd_channels_assertions (
  input wire        mclk,
  input wire        reset,
  input wire        regWrStb,
  input wire        regRdStb,
  input wire [31:0] regRdData,
  input wire [7:0]  rxData0,
  input wire [7:0]  rxData1,
  input wire [1:0]  rxReady,
  input wire [1:0]  txValid,
  input wire [7:0]  txData0,
  input wire [1:0]  txReady,
  input wire        memReq,
  input wire        memWrite,
  input wire [31:0] memAddr,
  input wire [7:0]  memWrData,
  input wire        memAck,
  input wire [1:0]  usartIrq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////
  // An access in flight must not change under the memory.
  a_mem_hold:
    assert property (memReq && !memAck |=> memReq && $stable(memAddr)
      && $stable(memWrite) && $stable(memWrData))
    else $error("memory request changed before its acknowledge");
  a_req_drop:
    assert property (memReq && memAck |=> !memReq)
    else $error("memory request stayed up after acknowledge");
  // A character taken from a receiver goes out as a memory write request on the next cycle.
  a_rx0_take:
    assert property (rxReady[0] |=> memReq && memWrite
      && memWrData == $past(rxData0))
    else $error("port 0 receive character not written");
  a_rx1_take:
    assert property (rxReady[1] |=> memReq && memWrite
      && memWrData == $past(rxData1))
    else $error("port 1 receive character not written");
  // The engine owns one access at a time, so one take per idle cycle.
  a_one_access:
    assert property (rxReady != 2'h0 |-> !memReq && rxReady != 2'h3)
    else $error("receive take while busy or on both ports");
  a_rd_idle:
    assert property (!regRdStb |=> regRdData == 32'h0)
    else $error("read data not zero outside its cycle");
  // An interrupt can only appear from a finished transfer or a mask write.
  a_irq_cause:
    assert property ($rose(usartIrq[0]) |-> $past(memAck) || $past(regWrStb))
    else $error("port 0 interrupt rose without a cause");
  a_tx_hold:
    assert property (txValid[0] && !txReady[0] |=> txValid[0]
      && $stable(txData0))
    else $error("transmit character dropped before it was taken");

  c_rx_take: cover property (rxReady[0]);
  c_tx_read: cover property (memReq && memAck && !memWrite);
  c_irq_up:  cover property (usartIrq[1]);
  c_tx_stall: cover property (txValid[0] && !txReady[0] [*4]);
endmodule

bind spd_channels spd_channels_assertions u_chk (
  .mclk(mclk), .reset(reset), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdData(regRdData), .rxData0(rxData0), .rxData1(rxData1),
  .rxReady(rxReady), .txValid(txValid), .txData0(txData0),
  .txReady(txReady), .memReq(memReq), .memWrite(memWrite),
  .memAddr(memAddr), .memWrData(memWrData), .memAck(memAck),
  .usartIrq(usartIrq));

// ==== spd_channels_tb_top.sv ====
// Self-checking bench for the serial DMA engine and its memory.
`timescale 1ns/1ps
module spd_channels_tb_top;
  logic        mclk, reset, regWrStb, regRdStb, slow, txStall, rdPend;
  logic [6:0]  regAddr;
  logic [31:0] regWrData, rxPtr [2], txBase [2];
  logic [1:0]  rxValid, txReady;
  logic [7:0]  rxD [2];
  wire  [7:0]  txD [2];
  wire  [31:0] regRdData, memAddr;
  wire  [1:0]  rxReady, txValid, usartIrq;
  wire         memReq, memWrite, memAck;
  wire  [7:0]  memWrData, memRdData;
  integer      fail_count, checked, cyc, rxTaken, i, p;
  // Expected results, noted by whoever drives the stimulus.
  logic [31:0] rdQ [$];
  logic [39:0] wrQ [$];
  logic [7:0]  txQ [2][$];
  // Offsets read back after reset; the last one is an unmapped hole.
  logic [5:0]  ofsList [7] = '{6'h10, 6'h14, 6'h30, 6'h34, 6'h38, 6'h3C,
                               6'h00};

  spd_channels u_dut (.mclk(mclk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .rxValid(rxValid), .rxData0(rxD[0]),
    .rxData1(rxD[1]), .rxReady(rxReady), .txValid(txValid),
    .txData0(txD[0]), .txData1(txD[1]), .txReady(txReady),
    .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memWrData(memWrData), .memRdData(memRdData), .memAck(memAck),
    .usartIrq(usartIrq));
  spd_mem_model u_mem (.mclk(mclk), .reset(reset), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memWrData(memWrData),
    .memRdData(memRdData), .memAck(memAck), .slow(slow));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparison and report.
  task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmpReg(logic [31:0] e, logic [31:0] g);
    chk("register", {8'h00, e}, {8'h00, g});
  endtask
  task automatic cmpMem(logic [39:0] e);
    chk("memory write", e, {memAddr, memWrData});
  endtask
  task automatic cmpChr(logic [7:0] e, logic [7:0] g);
    chk("tx char", {32'h0, e}, {32'h0, g});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Register bus: one-cycle strobes launched just after an edge.
  task automatic wr(int pt, logic [5:0] ofs, logic [31:0] d);
    @(posedge mclk);
    regAddr   <= {pt[0], ofs};
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge mclk);
    regWrStb  <= 1'b0;
  endtask
  task automatic rd(int pt, logic [5:0] ofs, logic [31:0] e);
    @(posedge mclk);
    regAddr  <= {pt[0], ofs};
    regRdStb <= 1'b1;
    rdQ.push_back(e);
    @(posedge mclk);
    regRdStb <= 1'b0;
  endtask
  task automatic waitIdle(int n);
    for (int k = 0; k < n && (wrQ.size() || txQ[0].size()
         || txQ[1].size() || memReq); k++) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Receivers, transmitters and the watcher that pops the notes.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict;
    end
    if (rdPend) cmpReg(rdQ.size() ? rdQ.pop_front() : 'x, regRdData);
    rdPend <= regRdStb;
    if (memReq && memAck && memWrite)
      cmpMem(wrQ.size() ? wrQ.pop_front() : 'x);
    txReady <= txStall ? 2'h0 : 2'($urandom);
    for (int u = 0; u < 2; u++) begin
      if (txValid[u] && txReady[u])
        cmpChr(txQ[u].size() ? txQ[u].pop_front() : 'x, txD[u]);
      if (rxValid[u] && rxReady[u]) begin
        wrQ.push_back({rxPtr[u], rxD[u]});
        rxPtr[u] = rxPtr[u] + 32'h1;
        rxD[u] <= 8'($urandom);
        rxTaken++;
      end
    end
  end

  initial begin
    void'($urandom(32'hCD0A));
    {fail_count, checked, cyc, rxTaken} = 0;
    {regWrStb, regRdStb, rdPend, slow, txStall} = 5'h0;
    {regAddr, regWrData, rxValid, txReady} = 0;
    rxD[0] = 8'($urandom);
    rxD[1] = 8'($urandom);
    for (i = 0; i < 256; i++) u_mem.mem[i] = 8'($urandom);
    reset = 1'b1;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    // Every register of both ports starts clear; a hole reads zero.
    for (p = 0; p < 2; p++)
      foreach (ofsList[k])
        rd(p, ofsList[k], 32'h0);
    $display("test reset values done");
    wr(1, 6'h30, 32'hFFFFFFFF);
    rd(1, 6'h30, 32'hFFFFFFFF);
    wr(1, 6'h34, 32'hFFFFFFFF);
    rd(1, 6'h34, 32'h0000FFFF);
    rd(0, 6'h34, 32'h0);
    $display("test register widths done");
    // Both receivers stream at once into slow memory; counts of three.
    slow <= 1'b1;
    for (p = 0; p < 2; p++) begin
      rxPtr[p] = ($urandom & 32'hFFFFFF00) | (p * 32'h40);
      wr(p, 6'h30, rxPtr[p]);
      wr(p, 6'h34, 32'h3);
    end
    rxValid <= 2'h3;
    for (i = 0; i < 400 && (rxTaken < 6 || wrQ.size()); i++) @(posedge mclk);
    repeat (20) @(posedge mclk);
    rxValid <= 2'h0;
    for (p = 0; p < 2; p++) begin
      rd(p, 6'h34, 32'h0);
      rd(p, 6'h30, rxPtr[p]);
      rd(p, 6'h14, 32'h1);
    end
    $display("test receive streams done");
    // Mask enable, disable, and a count write that clears the flag.
    wr(0, 6'h08, 32'h1);
    #1 cmpReg(32'h1, {30'h0, usartIrq});
    rd(0, 6'h10, 32'h1);
    wr(0, 6'h0C, 32'h1);
    #1 cmpReg(32'h0, {30'h0, usartIrq});
    wr(0, 6'h08, 32'h1);
    wr(0, 6'h34, 32'h0);
    #1 cmpReg(32'h0, {30'h0, usartIrq});
    wr(1, 6'h08, 32'h3);
    #1 cmpReg(32'h2, {30'h0, usartIrq});
    rd(1, 6'h08, 32'h0);
    wr(1, 6'h0C, 32'h3);
    $display("test interrupt mask done");
    // Transmitters stall; only two characters may be fetched ahead.
    txStall <= 1'b1;
    slow    <= 1'b0;
    for (p = 0; p < 2; p++) begin
      txBase[p] = ($urandom & 32'hFFFFFF00) | (32'h80 + p * 32'h40);
      for (i = 0; i < 5 - 2 * p; i++)
        txQ[p].push_back(u_mem.mem[txBase[p][7:0] + i]);
      wr(p, 6'h38, txBase[p]);
      wr(p, 6'h3C, 32'(5 - 2 * p));
    end
    repeat (40) @(posedge mclk);
    rd(0, 6'h3C, 32'h3);
    rd(1, 6'h3C, 32'h1);
    txStall <= 1'b0;
    waitIdle(600);
    rd(0, 6'h38, txBase[0] + 32'h5);
    rd(0, 6'h14, 32'h2);
    rd(1, 6'h14, 32'h3);
    repeat (3) @(posedge mclk);
    $display("test transmit stall done");
    print_verdict;
  end
endmodule
